// *** rtl/lwd_consts.svh ***
// Constants for the line wake-up detector: timing figures, register offsets,
// field positions and reset values.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef LWD_CONSTS_SVH
`define LWD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing figures (microseconds) and clock
// ----------------------------------------------------------------------------
`define LWD_CLK_HZ        10_000_000
`define LWD_WAKE_HOLD_US  80
`define LWD_WAKE_PULSE_US 200
`define LWD_BLANK_US      500

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LWD_OFS_STATUS 8'h00
`define LWD_OFS_MASK   8'h04
`define LWD_OFS_STATE  8'h08

// ----------------------------------------------------------------------------
// Event bit positions and reset values
// ----------------------------------------------------------------------------
`define LWD_EV_WAKE   0
`define LWD_EV_THERM  1
`define LWD_EV_SUPPLY 2
`define LWD_EV_W      3
`define LWD_MASK_RST  3'h0

`endif

// *** rtl/lwd_pkg.sv ***
// Types shared by the line wake-up detector.
// Assumes no other package.
package lwd_pkg;

  // Line pin in its two signals
  typedef struct packed {
    logic hi_drive;  // High side on
    logic lo_drive;  // Low side on
  } lwd_drive_t;

  // Supply and temperature monitor levels
  typedef struct packed {
    logic logic_above_min;  // Logic supply above 1.5 V
    logic logic_ok;         // At or above logic_supply_lockout_level
    logic field_low;        // Below field_supply_warning_level
    logic over_temp;        // Over-temperature indication
  } lwd_mon_t;

  typedef enum logic [1:0] {
    LWD_IDLE  = 2'b00,
    LWD_HOLD  = 2'b01,
    LWD_PULSE = 2'b10
  } lwd_state_t;

endpackage : lwd_pkg

// *** rtl/lwd_timer.sv ***
// Down-counting interval timer, reloaded by a start pulse.
// Assumes a single clock and clock enable from the parent.
`timescale 1ns/10ps
module lwd_timer
  import lwd_pkg::*;
#(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic start,
  output logic      busy
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;

  // Reload on start, count down otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (start) begin
        cnt_q <= W'(CYCLES);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

  assign busy = (cnt_q != '0);
endmodule : lwd_timer

// *** rtl/lwd_top.sv ***
// Line wake-up detector: line driver control, receive path, wake-up
// detection with blanking, supply warning and thermal shutdown.
// Assumes synchronous pin inputs and a single 10 MHz clock.
`timescale 1ns/10ps
`include "lwd_consts.svh"

// Operation
// - Wake-up is watched in push-pull, low-side-only and high-side-only modes.
// - Wake-up is recognised after the line is opposed continuously for 80 us.
// - Recognised wake-up drives wake_indicator_n low for one 200 us pulse.
// - Wake conditions are ignored 500 us after each driver state change.
// - With logic supply above 1.5 V, supply warning low on logic lockout, else low on field supply low.
// - Over-temperature turns off drivers and regulators until it clears.
// - Enabled driver outputs inverse transmit level; transmit disabled turns both off.
// - Receive is inverse of line level, held low while transceiver disabled.
module lwd_top
  import lwd_pkg::*;
#(
  parameter int unsigned CLK_HZ = `LWD_CLK_HZ,
  parameter bit          LO_ONLY = 1'b0,
  parameter bit          HI_ONLY = 1'b0
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       line_transceiver_enable,
  input  wire logic       transmit_drive_enable,
  input  wire logic       transmit_level,
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe,
  output logic            receive_level,
  output logic            wake_indicator_n,
  output logic            supply_low_warning_out,
  output logic            supply_low_warning_oe,
  input  wire lwd_mon_t   mon,
  output logic            regulators_on,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            irq
);

  // ---------------------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------------------
  // Counts from frequency
  localparam int unsigned HOLD_CYC  = (`LWD_WAKE_HOLD_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PULSE_CYC = (`LWD_WAKE_PULSE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BLANK_CYC = (`LWD_BLANK_US * (CLK_HZ / 1_000_000));
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);

  // ---------------------------------------------------------------------------
  // Line driver and receiver
  // ---------------------------------------------------------------------------
  lwd_drive_t drv_d, drv_q;
  logic       therm_q;

  always_comb begin
    drv_d = '0;
    if (line_transceiver_enable && transmit_drive_enable && !therm_q) begin
      drv_d.lo_drive = transmit_level && !HI_ONLY;
      drv_d.hi_drive = !transmit_level && !LO_ONLY;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drv_q <= '0;
    end else if (ce) begin
      drv_q <= drv_d;
    end
  end

  assign line_oe  = drv_q.hi_drive | drv_q.lo_drive;
  assign line_out = drv_q.hi_drive;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      receive_level <= 1'b0;
    end else if (ce) begin
      receive_level <= line_transceiver_enable & ~line_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Wake-up detection
  // ---------------------------------------------------------------------------
  logic       blank_busy, pulse_busy, pulse_start, drv_change, opposed;
  logic [HW-1:0] hold_q;
  lwd_state_t st_q;

  assign drv_change = (drv_d != drv_q);
  lwd_timer #(.CYCLES(BLANK_CYC)) u_blank (
    .mclk  (mclk),
    .nrst  (nrst),
    .ce    (ce),
    .start (drv_change),
    .busy  (blank_busy)
  );

  // Any active side can be opposed
  assign opposed = (drv_q.hi_drive && !line_in) || (drv_q.lo_drive && line_in);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= '0;
      st_q   <= LWD_IDLE;
    end else if (ce) begin
      unique case (st_q)
        LWD_IDLE: begin
          hold_q <= '0;
          if (opposed && !blank_busy && !drv_change) begin
            st_q <= LWD_HOLD;
          end
        end
        LWD_HOLD: begin
          if (!opposed || blank_busy || drv_change) begin
            st_q <= LWD_IDLE;
          end else if (hold_q == HW'(HOLD_CYC - 2)) begin
            st_q <= LWD_PULSE;
          end else begin
            hold_q <= hold_q + HW'(1);
          end
        end
        LWD_PULSE: begin
          if (!pulse_busy && !pulse_start) begin
            st_q <= LWD_IDLE;
          end
        end
        default: st_q <= LWD_IDLE;
      endcase
    end
  end

  assign pulse_start = (st_q == LWD_HOLD) && (hold_q == HW'(HOLD_CYC - 2)) && opposed
                       && !blank_busy && !drv_change;

  lwd_timer #(.CYCLES(PULSE_CYC)) u_pulse (
    .mclk  (mclk),
    .nrst  (nrst),
    .ce    (ce),
    .start (pulse_start),
    .busy  (pulse_busy)
  );
  assign wake_indicator_n = ~pulse_busy;

  // ---------------------------------------------------------------------------
  // Supply warning and thermal shutdown
  // ---------------------------------------------------------------------------
  logic warn_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      warn_q <= 1'b0;
    end else if (ce) begin
      warn_q <= mon.logic_above_min && (!mon.logic_ok || mon.field_low);
    end
  end
  assign supply_low_warning_out = 1'b0;
  assign supply_low_warning_oe  = warn_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      therm_q <= 1'b0;
    end else if (ce) begin
      therm_q <= mon.over_temp;
    end
  end
  assign regulators_on = ~therm_q;

  // ---------------------------------------------------------------------------
  // Registers and interrupt
  // ---------------------------------------------------------------------------
  logic [`LWD_EV_W-1:0] stat_q, mask_q, ev;
  logic                 warn_p, therm_p;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      warn_p  <= 1'b0;
      therm_p <= 1'b0;
    end else if (ce) begin
      warn_p  <= warn_q;
      therm_p <= therm_q;
    end
  end

  always_comb begin
    ev = '0;
    ev[`LWD_EV_WAKE]   = pulse_start;
    ev[`LWD_EV_THERM]  = therm_q & ~therm_p;
    ev[`LWD_EV_SUPPLY] = warn_q & ~warn_p;
  end

  // Sticky status, read clears, set wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else if (ce) begin
      if (reg_rd && reg_addr == `LWD_OFS_STATUS) begin
        stat_q <= ev;
      end else begin
        stat_q <= stat_q | ev;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= `LWD_MASK_RST;
    end else if (ce && reg_wr && reg_addr == `LWD_OFS_MASK) begin
      mask_q <= reg_wdata[`LWD_EV_W-1:0];
    end
  end

  // Read data one cycle later
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          `LWD_OFS_STATUS: reg_rdata <= {5'h00, stat_q};
          `LWD_OFS_MASK:   reg_rdata <= {5'h00, mask_q};
          `LWD_OFS_STATE:  reg_rdata <= {3'h0, therm_q, warn_q, blank_busy, ~wake_indicator_n, line_oe};
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [HW-1:0] opp_len_q;
  logic [PW-1:0] wake_len_q;

  // Run of opposed samples, saturating, for the hold check
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      opp_len_q <= '0;
    end else if (ce) begin
      if (!opposed) begin
        opp_len_q <= '0;
      end else if (opp_len_q != HW'(HOLD_CYC)) begin
        opp_len_q <= opp_len_q + HW'(1);
      end
    end
  end
  // Cycles spent in the wake pulse, for the length check
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wake_len_q <= '0;
    end else if (ce) begin
      if (pulse_start) begin
        wake_len_q <= '0;
      end else if (pulse_busy && wake_len_q != PW'(PULSE_CYC)) begin
        wake_len_q <= wake_len_q + PW'(1);
      end
    end
  end

  pulse_len_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(pulse_busy) |-> (wake_len_q == PW'(PULSE_CYC))) else $error("wake pulse length");
  blank_wake_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && (blank_busy || drv_change) && st_q != LWD_PULSE) |=> (st_q == LWD_IDLE)) else $error("blanking");
  blank_restart_a: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(drv_q) |-> blank_busy) else $error("blanking not restarted");
  rx_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && !line_transceiver_enable) |=> !receive_level) else $error("receive not gated");
  drv_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && !transmit_drive_enable) |=> !line_oe) else $error("driver not off");
  therm_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    ((ce && therm_q) |=> !line_oe) and ((ce && mon.over_temp) |=> !regulators_on)) else $error("thermal shutdown");
  hold_wake_a: assert property (@(posedge mclk) disable iff (!nrst)
    pulse_start |-> (opp_len_q >= HW'(HOLD_CYC - 1))) else $error("wake without hold");
  warn_drive_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && mon.logic_above_min && !mon.logic_ok) |=> supply_low_warning_oe) else $error("warning");
  wake_watch_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && st_q == LWD_IDLE && line_oe && line_in != line_out && !blank_busy && !drv_change) |=> st_q == LWD_HOLD)
    else $error("opposed line not watched");

endmodule : lwd_top

// *** verification/lwd_master_model.sv ***
// Line master model: answers the device line drive and shorts it on command.
// Assumes the bench raises short_cmd just after a clock edge.
`timescale 1ns/10ps
module lwd_master_model (
  input  wire logic mclk,
  input  wire logic line_out,
  input  wire logic line_oe,
  input  wire logic short_cmd,
  output logic      line_in
);
  // ----------------------------------------------------------------------------
  // Line level
  // ----------------------------------------------------------------------------
  logic idle_q = 1'b0;
  // Released line flips each cycle, never a stale value
  always_ff @(posedge mclk) begin
    idle_q <= ~idle_q;
  end
  // Short beats the device drive
  always_comb begin
    if (short_cmd) line_in = ~line_out;
    else if (line_oe) line_in = line_out;
    else line_in = idle_q;
  end
endmodule : lwd_master_model

// *** verification/lwd_top_tb.sv ***
// Bench for the line wake-up detector: pins, wake timing, supply, registers.
// Assumes the line master model and a 10 MHz clock.
`timescale 1ns/10ps
`include "lwd_consts.svh"
module lwd_top_tb;
  import lwd_pkg::*;
  localparam int unsigned CLK_HZ  = 10_000_000;
  localparam int          HOLD_C  = CLK_HZ / 1_000_000 * 80;
  localparam int          PULSE_C = CLK_HZ / 1_000_000 * 200;
  logic       mclk, nrst, ce, cq_en, tx_en, tx_lvl, line_in, line_out, line_oe, rx, wake_n;
  logic       warn_out, warn_oe, regs_on, reg_wr, reg_rd, irq, short_cmd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  lwd_mon_t   mon;
  int         bad_count, n_compared, cyc, at, w;

  lwd_top #(.CLK_HZ(CLK_HZ)) dut_u (.mclk(mclk), .nrst(nrst), .ce(ce), .line_transceiver_enable(cq_en),
    .transmit_drive_enable(tx_en), .transmit_level(tx_lvl), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .receive_level(rx), .wake_indicator_n(wake_n), .supply_low_warning_out(warn_out),
    .supply_low_warning_oe(warn_oe), .mon(mon), .regulators_on(regs_on), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  lwd_master_model mst_u (.mclk(mclk), .line_out(line_out), .line_oe(line_oe), .short_cmd(short_cmd),
    .line_in(line_in));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("counts: %0d compared, %0d mismatched", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk); reg_rd <= 1'b0;
    @(negedge mclk); v = reg_rdata;
    @(posedge mclk);
  endtask : rd
  task automatic pins(logic e, logic t, logic x);
    cq_en <= e; tx_en <= t; tx_lvl <= x;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check("line_oe", line_oe, e & t);
    check("line_out", line_out & e & t, ~x & e & t);
    check("receive", rx & (~e | t), e & t & x);
    @(posedge mclk);
  endtask : pins
  // Shorts the line for n cycles, at = first cycle with wake low
  task automatic opp(int n);
    at = -1;
    short_cmd <= 1'b1;
    for (int i = 1; i <= n + 4; i++) begin
      @(posedge mclk);
      if (i == n) short_cmd <= 1'b0;
      @(negedge mclk);
      if (wake_n === 1'b0 && at < 0) at = i;
    end
    @(posedge mclk);
  endtask : opp

  // Clock and timeout
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    nrst = 1'b0; ce = 1'b1; cq_en = 1'b0; tx_en = 1'b0; tx_lvl = 1'b0; short_cmd = 1'b0;
    mon = 4'hc; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    void'($urandom(32'h9838));
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    check("reset", {irq, regs_on, wake_n, line_oe}, 8'h06);
    @(posedge mclk); nrst <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      pins(r[0], r[1], r[2]);
    end
    $display("done: pins");
    wr(`LWD_OFS_MASK, 8'h01);
    pins(1'b1, 1'b1, 1'b0);
    repeat (5100) @(posedge mclk);
    // Too short, then held long enough
    opp(HOLD_C - 1);
    check("short_hold", 8'(at), 8'hff);
    opp(HOLD_C + 10);
    check("hold_ok", (at == HOLD_C || at == HOLD_C + 1), 8'h01);
    // Low samples already seen inside opp, less the closing high one
    w = HOLD_C + 14 - at;
    while (wake_n === 1'b0 && w < PULSE_C + 20) begin
      @(negedge mclk); w++;
    end
    check("pulse_len", (w == PULSE_C || w == PULSE_C + 1), 8'h01);
    check("irq_on", irq, 8'h01);
    @(posedge mclk); rd(`LWD_OFS_STATUS);
    check("status", v, 8'h01);
    @(negedge mclk); check("irq_off", irq, 8'h00);
    $display("done: wake");
    @(posedge mclk); tx_lvl <= 1'b1;
    repeat (3000) @(posedge mclk);
    tx_lvl <= 1'b0;
    repeat (2500) @(posedge mclk);
    opp(1500);
    check("blank", 8'(at), 8'hff);
    $display("done: blanking");
    // Clock enable low freezes the driver
    ce <= 1'b0;
    tx_lvl <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check("ce_freeze", {line_oe, line_out}, 8'h03);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (5100) @(posedge mclk);
    opp(HOLD_C + 10);
    check("lo_side", (at == HOLD_C || at == HOLD_C + 1), 8'h01);
    rd(`LWD_OFS_STATUS);
    check("lo_status", v, 8'h01);
    $display("done: freeze and low side");
    wr(`LWD_OFS_MASK, 8'h00);
    for (int m = 0; m < 16; m++) begin
      mon <= m[3:0];
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check("warn", {warn_out, warn_oe}, {7'h0, mon[3] & (~mon[2] | mon[1])});
      check("thermal", {regs_on, line_oe & mon[0]}, {~mon[0], 1'b0});
      @(posedge mclk);
    end
    mon <= 4'hc;
    check("irq_masked", irq, 8'h00);
    rd(`LWD_OFS_STATUS);
    check("events", v, 8'h06);
    rd(8'hfc);
    check("unmapped", v, 8'h00);
    wr(`LWD_OFS_MASK, 8'h05);
    rd(`LWD_OFS_MASK);
    check("mask", v, 8'h05);
    // Second reset in mid-run clears mask and interrupt
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(`LWD_OFS_MASK);
    check("mask_reset", v, 8'h00);
    check("irq_reset", irq, 8'h00);
    $display("done: supply, registers and reset");
    tally_and_finish();
  end
endmodule : lwd_top_tb
